// >>> scr_pkg.sv
// Purpose: Shared constants of the synthesizer, oscillator and power
//          configuration register bank.
// Assumes: 8-bit registers on an 8-bit address space.
// Notes:   Reserved bits are read-only and hold their reset value.
package scr_pkg;

	localparam int          SCR_AW   = 8;
	localparam int          SCR_DW   = 8;
	localparam int          SCR_NREG = 13;
	localparam int          SCR_IW   = 4;

	// Register indices
	localparam int SCR_IX_PUMP  = 0;
	localparam int SCR_IX_VCO   = 1;
	localparam int SCR_IX_VIN2  = 2;
	localparam int SCR_IX_VIN1  = 3;
	localparam int SCR_IX_VIN0  = 4;
	localparam int SCR_IX_CDIV  = 5;
	localparam int SCR_IX_OSC   = 6;
	localparam int SCR_IX_TRMH  = 7;
	localparam int SCR_IX_TRML  = 8;
	localparam int SCR_IX_REG   = 9;
	localparam int SCR_IX_SWCK  = 10;
	localparam int SCR_IX_RATL  = 11;
	localparam int SCR_IX_BATT  = 12;

	localparam logic [7:0] SCR_OFFS [SCR_NREG] = '{
		8'h65, 8'h68, 8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h6d,
		8'h6e, 8'h6f, 8'h75, 8'h76, 8'h77, 8'h78};
	localparam logic [7:0] SCR_RSTV [SCR_NREG] = '{
		8'hd0, 8'h03, 8'h88, 8'h40, 8'h40, 8'h45, 8'h30,
		8'h70, 8'h4d, 8'h17, 8'h20, 8'h00, 8'h39};
	// Writable bits; all others are reserved
	localparam logic [7:0] SCR_WMSK [SCR_NREG] = '{
		8'h04, 8'h30, 8'h00, 8'h00, 8'h00, 8'h10, 8'hfb,
		8'hff, 8'h80, 8'h20, 8'hff, 8'hff, 8'h7c};

	// Status register, read only
	localparam logic [7:0] SCR_STATUS_OFFS = 8'h7f;

	// Field positions
	localparam int SCR_B_BOOST    = 2;
	localparam int SCR_B_AMPBYP   = 5;
	localparam int SCR_B_FRQBYP   = 4;
	localparam int SCR_B_DIVOFF   = 4;
	localparam int SCR_B_REFSEL   = 7;
	localparam int SCR_B_GM_HI    = 6;
	localparam int SCR_B_GM_LO    = 4;
	localparam int SCR_B_REFERENCE_DIVIDER_EN   = 3;
	localparam int SCR_B_LFPIN    = 1;
	localparam int SCR_B_LFCAL    = 0;
	localparam int SCR_B_TRIM_HI  = 7;
	localparam int SCR_B_TRIM_LO  = 4;
	localparam int SCR_B_FBK_HI   = 3;
	localparam int SCR_B_FBK_LO   = 0;
	localparam int SCR_B_FBK_LSB  = 7;
	localparam int SCR_B_REGOFF   = 5;
	localparam int SCR_B_RMSEL    = 7;
	localparam int SCR_B_RAT_HI   = 6;
	localparam int SCR_B_BATTEN   = 6;
	localparam int SCR_B_BTH_HI   = 5;
	localparam int SCR_B_BTH_LO   = 4;
	localparam int SCR_B_LVLMODE  = 3;
	localparam int SCR_B_BYPASS   = 2;
	localparam int SCR_B_ST_SWRUN = 0;
	localparam int SCR_B_ST_LFSEEN = 1;
	localparam int SCR_B_ST_FIXED = 2;

	// Switching clock
	localparam int SCR_RATIO_W   = 15;
	localparam int SCR_DIV4_W    = 2;

	// Address to register index; SCR_NREG means unmapped
	function automatic logic [SCR_IW-1:0] scr_find(
		input logic [SCR_AW-1:0] addr);
		logic [SCR_IW-1:0] ix;
		ix = SCR_IW'(SCR_NREG);
		for (int k = 0; k < SCR_NREG; k++) begin
			if (addr == SCR_OFFS[k]) begin
				ix = SCR_IW'(k);
			end
		end
		return ix;
	endfunction : scr_find

endpackage : scr_pkg

// >>> scr_swclk_gen.sv
// Purpose: Regulator switching clock, divide by four or rate multiplier.
// Assumes: Runs on the digital clock.
// Notes:   Output is low while disabled.
`timescale 1ns/1ps
module scr_swclk_gen
	import scr_pkg::*;
#(
	parameter int RATIO_W = SCR_RATIO_W
) (
	// Clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	// Control
	input  wire logic               i_en,
	input  wire logic               i_rm_sel,
	input  wire logic [RATIO_W-1:0] i_ratio,
	// Output
	output logic                    o_sw_clk
);

	logic [SCR_DIV4_W-1:0] div_q;
	logic [SCR_DIV4_W-1:0] div_d;
	logic [RATIO_W-1:0]    acc_q;
	logic [RATIO_W:0]      acc_sum;
	logic                  sw_d;

	// Carry of the accumulator fires ratio times per 2^RATIO_W clocks
	assign acc_sum = {1'b0, acc_q} + {1'b0, i_ratio};
	assign div_d   = div_q + SCR_DIV4_W'(1);
	assign sw_d    = !i_en ? 1'b0 :
	                 i_rm_sel ? acc_sum[RATIO_W] : div_q[SCR_DIV4_W-1];

	always_ff @(posedge i_clk) begin
		if (i_rst || !i_en) begin
			div_q    <= '0;
			acc_q    <= '0;
			o_sw_clk <= 1'b0;
		end else begin
			div_q    <= div_d;
			acc_q    <= acc_sum[RATIO_W-1:0];
			o_sw_clk <= sw_d;
		end
	end

endmodule : scr_swclk_gen

// >>> scr_lf_src.sv
// Purpose: Low-frequency clock source select, internal tick or pin.
// Assumes: Pin is asynchronous; internal tick is on the same clock.
// Notes:   One-cycle tick per rising pin edge.
`timescale 1ns/1ps
module scr_lf_src (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// Sources
	input  wire logic i_sel_pin,
	input  wire logic i_pin,
	input  wire logic i_rc_tick,
	// Output
	output logic      o_tick
);

	logic meta_q;
	logic sync_q;
	logic last_q;
	logic pin_rise;

	assign pin_rise = sync_q && !last_q;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
			o_tick <= 1'b0;
		end else begin
			meta_q <= i_pin;
			sync_q <= meta_q;
			last_q <= sync_q;
			o_tick <= i_sel_pin ? pin_rise : i_rc_tick;
		end
	end

endmodule : scr_lf_src

// >>> scr_top.sv
// Purpose: Synthesizer, oscillator and power configuration register
//          bank with the logic its fields steer.
// Assumes: Plain register port, read data one cycle after the strobe.
// Notes:   Reserved bits read back their reset value.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module scr_top
	import scr_pkg::*;
#(
	parameter int RATIO_W = SCR_RATIO_W
) (
	// Clock and reset
	input  wire logic              I_CLOCK,
	input  wire logic              I_RST,
	// Register port
	input  wire logic [SCR_AW-1:0] I_ADDR,
	input  wire logic [SCR_DW-1:0] I_WDATA,
	input  wire logic              I_WR,
	input  wire logic              I_RD,
	output logic      [SCR_DW-1:0] O_RDATA,
	// Synthesizer
	output logic                   O_DOWN_PULSE_BOOST_EN,
	// VCO calibration words
	input  wire logic [3:0]        I_VCO_AMP_AUTO,
	input  wire logic [3:0]        I_VCO_AMP_EXT,
	input  wire logic [6:0]        I_VCO_FREQ_AUTO,
	input  wire logic [6:0]        I_VCO_FREQ_EXT,
	output logic      [3:0]        O_VCO_AMP_WORD,
	output logic      [6:0]        O_VCO_FREQ_WORD,
	output logic                   O_AMP_CAL_BYPASS,
	output logic                   O_FREQ_CAL_BYPASS,
	// Clock dividers and reference
	output logic                   O_DIG_CLKDIV_EN,
	output logic                   O_IF_CONV_CLK_EN,
	output logic                   O_REFERENCE_SOURCE_SEL,
	output logic      [2:0]        O_XTAL_DRIVE_STRENGTH,
	output logic                   O_REFERENCE_DIVIDER_EN,
	// Low-frequency oscillator
	input  wire logic              I_LF_PIN,
	input  wire logic              I_LF_RC_TICK,
	output logic                   O_LF_TICK,
	output logic                   O_LOWFREQ_CLOCK_FROM_PIN,
	output logic                   O_LOWFREQ_OSC_AUTOCAL_EN,
	output logic      [3:0]        O_OSC_TRIM_WORD,
	output logic      [4:0]        O_OSC_FEEDBACK_WORD,
	// Power management
	input  wire logic              I_RADIO_RX,
	output logic                   O_INTERNAL_REGULATOR_OFF,
	output logic                   O_SW_CLK,
	output logic                   O_BATTERY_DETECTOR_EN,
	output logic      [1:0]        O_BATTERY_THRESHOLD,
	output logic                   O_REG_LEVEL_FIXED,
	output logic                   O_LINEAR_REGULATOR_BYPASS
);

	// Register file
	logic [SCR_DW-1:0] reg_q [SCR_NREG];
	logic [SCR_IW-1:0] wr_ix;
	logic [SCR_IW-1:0] rd_ix;
	logic              rd_hit;
	logic              rd_status;
	logic [SCR_DW-1:0] rd_sel;
	logic [SCR_DW-1:0] rdata_d;
	logic [SCR_DW-1:0] status_w;

	// Field views
	logic [SCR_DW-1:0] pump_r;
	logic [SCR_DW-1:0] vco_r;
	logic [SCR_DW-1:0] cdiv_r;
	logic [SCR_DW-1:0] osc_r;
	logic [SCR_DW-1:0] trmh_r;
	logic [SCR_DW-1:0] trml_r;
	logic [SCR_DW-1:0] regc_r;
	logic [SCR_DW-1:0] swck_r;
	logic [SCR_DW-1:0] ratl_r;
	logic [SCR_DW-1:0] batt_r;

	// Derived controls
	logic               div_off;
	logic               reg_off;
	logic               amp_cal_bypass;
	logic               freq_cal_bypass;
	logic               rate_multiplier_sel;
	logic [RATIO_W-1:0] switching_ratio;
	logic               sw_en;
	logic               regulator_level_mode;
	logic               level_fixed_d;
	logic               lf_tick;
	logic               sw_clk;

	// Status
	logic lf_seen_q;
	logic lf_seen_d;
	logic status_rd;

	// Address decode
	assign wr_ix     = scr_find(I_ADDR);
	assign rd_ix     = wr_ix;
	assign rd_hit    = rd_ix < SCR_IW'(SCR_NREG);
	assign rd_status = I_ADDR == SCR_STATUS_OFFS;
	assign status_rd = I_RD && rd_status;

	// Registers with per-bit write masks
	genvar g;
	generate
		for (g = 0; g < SCR_NREG; g++) begin : g_reg
			logic hit;
			assign hit = I_WR && (wr_ix == SCR_IW'(g));
			always_ff @(posedge I_CLOCK) begin
				if (I_RST) begin
					reg_q[g] <= SCR_RSTV[g];
				end else if (hit) begin
					reg_q[g] <= (reg_q[g] & ~SCR_WMSK[g]) |
					            (I_WDATA & SCR_WMSK[g]);
				end
			end
		end
	endgenerate

	// Read path
	assign rd_sel  = rd_hit ? reg_q[rd_ix[SCR_IW-1:0]] : '0;
	assign rdata_d = !I_RD     ? '0 :
	                 rd_status ? status_w : rd_sel;

	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			O_RDATA <= '0;
		end else begin
			O_RDATA <= rdata_d;
		end
	end

	// Register views
	assign pump_r = reg_q[SCR_IX_PUMP];
	assign vco_r  = reg_q[SCR_IX_VCO];
	assign cdiv_r = reg_q[SCR_IX_CDIV];
	assign osc_r  = reg_q[SCR_IX_OSC];
	assign trmh_r = reg_q[SCR_IX_TRMH];
	assign trml_r = reg_q[SCR_IX_TRML];
	assign regc_r = reg_q[SCR_IX_REG];
	assign swck_r = reg_q[SCR_IX_SWCK];
	assign ratl_r = reg_q[SCR_IX_RATL];
	assign batt_r = reg_q[SCR_IX_BATT];

	// Synthesizer
	assign O_DOWN_PULSE_BOOST_EN = pump_r[SCR_B_BOOST];

	// VCO calibration bypass
	assign amp_cal_bypass    = vco_r[SCR_B_AMPBYP];
	assign freq_cal_bypass   = vco_r[SCR_B_FRQBYP];
	assign O_AMP_CAL_BYPASS  = amp_cal_bypass;
	assign O_FREQ_CAL_BYPASS = freq_cal_bypass;

	// Applied words change only on a clock edge
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			O_VCO_AMP_WORD  <= '0;
			O_VCO_FREQ_WORD <= '0;
		end else begin
			O_VCO_AMP_WORD  <= amp_cal_bypass ?
			                   I_VCO_AMP_EXT : I_VCO_AMP_AUTO;
			O_VCO_FREQ_WORD <= freq_cal_bypass ?
			                   I_VCO_FREQ_EXT : I_VCO_FREQ_AUTO;
		end
	end

	// Clock dividers
	assign div_off          = cdiv_r[SCR_B_DIVOFF];
	assign O_DIG_CLKDIV_EN  = !div_off;
	assign O_IF_CONV_CLK_EN = !div_off;

	// Reference selection
	assign O_REFERENCE_SOURCE_SEL = osc_r[SCR_B_REFSEL];
	assign O_XTAL_DRIVE_STRENGTH  =
		osc_r[SCR_B_GM_HI:SCR_B_GM_LO];
	assign O_REFERENCE_DIVIDER_EN = osc_r[SCR_B_REFERENCE_DIVIDER_EN];

	// Low-frequency oscillator
	assign O_LOWFREQ_CLOCK_FROM_PIN = osc_r[SCR_B_LFPIN];
	assign O_LOWFREQ_OSC_AUTOCAL_EN = osc_r[SCR_B_LFCAL];
	assign O_OSC_TRIM_WORD =
		trmh_r[SCR_B_TRIM_HI:SCR_B_TRIM_LO];
	assign O_OSC_FEEDBACK_WORD = {
		trmh_r[SCR_B_FBK_HI:SCR_B_FBK_LO],
		trml_r[SCR_B_FBK_LSB]};

	// Pin source is synchronised inside before use
	scr_lf_src u_lf_src (
		.i_clk     (I_CLOCK),
		.i_rst     (I_RST),
		.i_sel_pin (osc_r[SCR_B_LFPIN]),
		.i_pin     (I_LF_PIN),
		.i_rc_tick (I_LF_RC_TICK),
		.o_tick    (lf_tick)
	);

	assign O_LF_TICK = lf_tick;

	// Regulator
	assign reg_off = regc_r[SCR_B_REGOFF];
	assign O_INTERNAL_REGULATOR_OFF = reg_off;

	// Switching clock
	assign rate_multiplier_sel = swck_r[SCR_B_RMSEL];
	assign switching_ratio = {
		swck_r[SCR_B_RAT_HI:0], ratl_r};
	// Stops when dividers are off or regulator is off
	assign sw_en = !div_off && !reg_off;

	scr_swclk_gen #(
		.RATIO_W (RATIO_W)
	) u_swclk (
		.i_clk    (I_CLOCK),
		.i_rst    (I_RST),
		.i_en     (sw_en),
		.i_rm_sel (rate_multiplier_sel),
		.i_ratio  (switching_ratio),
		.o_sw_clk (sw_clk)
	);

	assign O_SW_CLK = sw_clk;

	// Battery monitor
	assign O_BATTERY_DETECTOR_EN = batt_r[SCR_B_BATTEN];
	assign O_BATTERY_THRESHOLD   = batt_r[SCR_B_BTH_HI:SCR_B_BTH_LO];
	assign regulator_level_mode  = batt_r[SCR_B_LVLMODE];
	// Receive level pinned to the fixed value in this mode
	assign level_fixed_d = regulator_level_mode && I_RADIO_RX;
	// Passed through as stored; software keeps it low
	assign O_LINEAR_REGULATOR_BYPASS = batt_r[SCR_B_BYPASS];

	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			O_REG_LEVEL_FIXED <= 1'b0;
		end else begin
			O_REG_LEVEL_FIXED <= level_fixed_d;
		end
	end

	// Sticky low-frequency tick flag, cleared by status read; set wins
	assign lf_seen_d = lf_tick ? 1'b1 :
	                   status_rd ? 1'b0 : lf_seen_q;

	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			lf_seen_q <= 1'b0;
		end else begin
			lf_seen_q <= lf_seen_d;
		end
	end

	// Status word
	always_comb begin
		status_w                  = '0;
		status_w[SCR_B_ST_SWRUN]  = sw_en;
		status_w[SCR_B_ST_LFSEEN] = lf_seen_q;
		status_w[SCR_B_ST_FIXED]  = O_REG_LEVEL_FIXED;
	end

endmodule : scr_top

// >>> scr_top_asserts.sv
// Purpose: Concurrent checks on the register bank ports.
// Assumes: Single clock domain, synchronous active-high reset.
// Notes:   Tracks the switching mode bit from observed writes.
`timescale 1ns/1ps
module scr_top_asserts
	import scr_pkg::*;
(
	// Clock and reset
	input wire logic              I_CLOCK,
	input wire logic              I_RST,
	// Register port
	input wire logic [SCR_AW-1:0] I_ADDR,
	input wire logic [SCR_DW-1:0] I_WDATA,
	input wire logic              I_WR,
	input wire logic              I_RD,
	input wire logic [SCR_DW-1:0] O_RDATA,
	// Fields
	input wire logic              O_DOWN_PULSE_BOOST_EN,
	input wire logic              O_DIG_CLKDIV_EN,
	input wire logic              O_REFERENCE_SOURCE_SEL,
	input wire logic [2:0]        O_XTAL_DRIVE_STRENGTH,
	input wire logic              O_REFERENCE_DIVIDER_EN,
	input wire logic              O_LOWFREQ_CLOCK_FROM_PIN,
	input wire logic              O_LOWFREQ_OSC_AUTOCAL_EN,
	input wire logic [3:0]        O_OSC_TRIM_WORD,
	input wire logic [4:0]        O_OSC_FEEDBACK_WORD,
	input wire logic              O_INTERNAL_REGULATOR_OFF,
	input wire logic              O_SW_CLK
);
	logic rm_q;
	wire logic sw_en = O_DIG_CLKDIV_EN && !O_INTERNAL_REGULATOR_OFF;

	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			rm_q <= 1'b0;
		end else if (I_WR && I_ADDR == 8'h76) begin
			rm_q <= I_WDATA[7];
		end
	end

	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);

	a_boost_follow: assert property (
		I_WR && I_ADDR == 8'h65 |=>
		O_DOWN_PULSE_BOOST_EN == $past(I_WDATA[2])) else $error("boost bit");
	a_unmapped_zero: assert property (
		I_RD && I_ADDR == 8'h70 |=> O_RDATA == 8'h00)
		else $error("unmapped read not zero");
	a_div_off: assert property (
		I_WR && I_ADDR == 8'h6c |=> O_DIG_CLKDIV_EN != $past(I_WDATA[4]))
		else $error("divider enable wrong");
	a_regulator_off: assert property (
		I_WR && I_ADDR == 8'h75 |=>
		O_INTERNAL_REGULATOR_OFF == $past(I_WDATA[5])) else $error("reg off");
	a_sw_square: assert property (
		disable iff (I_RST || rm_q || !sw_en)
		$rose(O_SW_CLK) |=> O_SW_CLK ##1 !O_SW_CLK [*2] ##1 O_SW_CLK)
		else $error("divide by four shape wrong");
	a_sw_stopped: assert property (
		!sw_en |=> !O_SW_CLK) else $error("switching clock runs when off");
	a_osc_read: assert property (
		I_RD && I_ADDR == 8'h6d |=> O_RDATA == {$past(O_REFERENCE_SOURCE_SEL),
		$past(O_XTAL_DRIVE_STRENGTH), $past(O_REFERENCE_DIVIDER_EN), 1'b0,
		$past(O_LOWFREQ_CLOCK_FROM_PIN), $past(O_LOWFREQ_OSC_AUTOCAL_EN)})
		else $error("oscillator fields differ from readback");
	a_trim_read: assert property (
		I_RD && I_ADDR == 8'h6e |=> O_RDATA ==
		{$past(O_OSC_TRIM_WORD), $past(O_OSC_FEEDBACK_WORD[4:1])})
		else $error("trim words differ from readback");
endmodule : scr_top_asserts

bind scr_top scr_top_asserts u_chk (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
	.I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
	.O_RDATA(O_RDATA), .O_DOWN_PULSE_BOOST_EN(O_DOWN_PULSE_BOOST_EN),
	.O_DIG_CLKDIV_EN(O_DIG_CLKDIV_EN),
	.O_REFERENCE_SOURCE_SEL(O_REFERENCE_SOURCE_SEL),
	.O_XTAL_DRIVE_STRENGTH(O_XTAL_DRIVE_STRENGTH),
	.O_REFERENCE_DIVIDER_EN(O_REFERENCE_DIVIDER_EN),
	.O_LOWFREQ_CLOCK_FROM_PIN(O_LOWFREQ_CLOCK_FROM_PIN),
	.O_LOWFREQ_OSC_AUTOCAL_EN(O_LOWFREQ_OSC_AUTOCAL_EN),
	.O_OSC_TRIM_WORD(O_OSC_TRIM_WORD),
	.O_OSC_FEEDBACK_WORD(O_OSC_FEEDBACK_WORD),
	.O_INTERNAL_REGULATOR_OFF(O_INTERNAL_REGULATOR_OFF),
	.O_SW_CLK(O_SW_CLK));

// >>> tb_top.sv
// Purpose: Directed register and field tests of the bank.
// Assumes: Bench drives the register port and side inputs itself.
// Notes:   Rate multiplier run spans one full accumulator cycle.
`timescale 1ns/1ps
module tb_top
	import scr_pkg::*;
;
	logic       clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
	logic       lf_pin = 1'b0, rc_tick = 1'b0, rx = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d, wd, ev;
	logic [3:0] amp_a = 4'h5, amp_e = 4'ha, ampw, trim;
	logic [6:0] frq_a = 7'h15, frq_e = 7'h6a, frqw;
	logic [4:0] fbk;
	logic [2:0] xtal;
	logic [1:0] bth;
	logic       boost, ampb, frqb, diven, ifen, refsel, reference_divider_en, lfpin;
	logic       lfcal, lftick, regoff, swclk, bden, lvlfix, ldobyp, b;
	int         mismatches = 0, n_compared = 0, c;

	always #25 clk = ~clk;

	scr_top u_dut (.I_CLOCK(clk), .I_RST(rst), .I_ADDR(addr),
		.I_WDATA(wdata), .I_WR(wr_en), .I_RD(rd_en), .O_RDATA(rdata),
		.O_DOWN_PULSE_BOOST_EN(boost), .I_VCO_AMP_AUTO(amp_a),
		.I_VCO_AMP_EXT(amp_e), .I_VCO_FREQ_AUTO(frq_a),
		.I_VCO_FREQ_EXT(frq_e), .O_VCO_AMP_WORD(ampw),
		.O_VCO_FREQ_WORD(frqw), .O_AMP_CAL_BYPASS(ampb),
		.O_FREQ_CAL_BYPASS(frqb), .O_DIG_CLKDIV_EN(diven),
		.O_IF_CONV_CLK_EN(ifen), .O_REFERENCE_SOURCE_SEL(refsel),
		.O_XTAL_DRIVE_STRENGTH(xtal), .O_REFERENCE_DIVIDER_EN(reference_divider_en),
		.I_LF_PIN(lf_pin), .I_LF_RC_TICK(rc_tick), .O_LF_TICK(lftick),
		.O_LOWFREQ_CLOCK_FROM_PIN(lfpin), .O_LOWFREQ_OSC_AUTOCAL_EN(lfcal),
		.O_OSC_TRIM_WORD(trim), .O_OSC_FEEDBACK_WORD(fbk),
		.I_RADIO_RX(rx), .O_INTERNAL_REGULATOR_OFF(regoff),
		.O_SW_CLK(swclk), .O_BATTERY_DETECTOR_EN(bden),
		.O_BATTERY_THRESHOLD(bth), .O_REG_LEVEL_FIXED(lvlfix),
		.O_LINEAR_REGULATOR_BYPASS(ldobyp));

	task automatic complete_run();
		$display("Compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wreg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		#1;
	endtask : wreg

	task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(16'(rdata), 16'(exp));
	endtask : rreg

	// Counts sampled high cycles of the switching clock or the tick
	task automatic cnt(input int n, input bit sw, output int k);
		k = 0;
		repeat (n) begin
			#1;
			if ((sw ? swclk : lftick) === 1'b1) k++;
			@(posedge clk);
		end
	endtask : cnt

	initial begin
		#(50 * 45000);
		mismatches++;
		complete_run();
	end

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int k = 0; k < SCR_NREG; k++) begin
			rreg(SCR_OFFS[k], SCR_RSTV[k]);
		end
		chk(16'(boost), 16'h0);
		chk(16'(xtal), 16'h3);
		$display("Test defaults done");
		for (int p = 0; p < 2; p++) begin
			d = p ? 8'h00 : 8'hff;
			b = d[0];
			for (int k = 0; k < SCR_NREG; k++) begin
				wd = (SCR_OFFS[k] == 8'h78) ? (d & 8'hfb) : d;
				wreg(SCR_OFFS[k], wd);
				ev = (SCR_RSTV[k] & ~SCR_WMSK[k]) | (wd & SCR_WMSK[k]);
				rreg(SCR_OFFS[k], ev);
			end
			chk(16'(boost), 16'(b));
			chk(16'({ampb, frqb}), 16'({2{b}}));
			chk(16'({diven, ifen}), 16'({2{!b}}));
			chk(16'(refsel), 16'(b));
			chk(16'(xtal), 16'({3{b}}));
			chk(16'(reference_divider_en), 16'(b));
			chk(16'(lfpin), 16'(b));
			chk(16'(lfcal), 16'(b));
			chk(16'({trim, fbk}), 16'({9{b}}));
			chk(16'(regoff), 16'(b));
			chk(16'({bden, bth}), 16'({3{b}}));
			chk(16'(ldobyp), 16'h0);
		end
		wreg(8'h70, 8'hff);
		rreg(8'h70, 8'h00);
		$display("Test access done");
		for (int m = 0; m < 4; m++) begin
			wreg(8'h68, 8'(m << 4));
			@(posedge clk);
			#1;
			chk(16'(ampw), 16'(m[1] ? amp_e : amp_a));
			chk(16'(frqw), 16'(m[0] ? frq_e : frq_a));
			wreg(8'h78, 8'(m[1] << 3));
			@(posedge clk);
			rx <= m[0];
			repeat (2) @(posedge clk);
			#1;
			chk(16'(lvlfix), 16'(m[1] & m[0]));
		end
		$display("Test calibration and level done");
		for (int s = 0; s < 2; s++) begin
			wreg(8'h6d, 8'(s << 1));
			@(posedge clk);
			rc_tick <= 1'b1;
			@(posedge clk);
			rc_tick <= 1'b0;
			cnt(6, 1'b0, c);
			chk(16'(c), 16'(1 - s));
			lf_pin <= 1'b1;
			cnt(10, 1'b0, c);
			lf_pin <= 1'b0;
			chk(16'(c), 16'(s));
		end
		// Status: clock running, tick seen, level fixed; read clears seen
		rreg(SCR_STATUS_OFFS, 8'h07);
		rreg(SCR_STATUS_OFFS, 8'h05);
		$display("Test low-frequency source done");
		wreg(8'h6d, 8'h00);
		repeat (8) @(posedge clk);
		cnt(64, 1'b1, c);
		chk(16'(c), 16'd32);
		wreg(8'h77, 8'h40);
		wreg(8'h76, 8'h81);
		repeat (8) @(posedge clk);
		cnt(32768, 1'b1, c);
		chk(16'(c), 16'd320);
		wreg(8'h75, 8'h20);
		// Last pulse may launch on the write edge itself
		@(posedge clk);
		cnt(64, 1'b1, c);
		chk(16'(c), 16'd0);
		wreg(8'h75, 8'h00);
		wreg(8'h6c, 8'h10);
		@(posedge clk);
		cnt(64, 1'b1, c);
		chk(16'(c), 16'd0);
		wreg(8'h6c, 8'h00);
		wreg(8'h76, 8'h00);
		repeat (8) @(posedge clk);
		cnt(64, 1'b1, c);
		chk(16'(c), 16'd32);
		$display("Test switching clock done");
		complete_run();
	end
endmodule : tb_top
